// *** core/hpc_top.sv ***
// haptic playback mode control: system states, source select, drive level
// assumes controls come from a register file elsewhere, on the same clock
`timescale 1ns/100ps
`default_nettype none
module hpc_top
    import hpc_pkg::*;
#(
    parameter int HALF_PERIOD = HALF_PERIOD_DEF
) (
    input  wire logic       core_clk_i,
    input  wire logic       rst_i,
    input  wire logic [2:0] source_sel_i,
    input  wire logic       standby_en_i,
    input  wire logic       boost_en_i,
    input  wire logic       closed_loop_i,
    input  wire logic       is_lra_i,
    input  wire logic [7:0] streamed_drive_level_i,
    input  wire logic       streamed_level_wr_i,
    input  wire logic [7:0] min_duty_threshold_i,
    input  wire logic       sequence_trigger_i,
    input  wire logic       sequence_done_i,
    input  wire logic       fault_i,
    input  wire logic [2:0] gpi_i,
    input  wire logic [5:0] gpi_edge_cfg_i,
    input  wire logic       pwm_stream_input_pin_i,
    output hpc_state_e      state_o,
    output logic            back_emf_enable_o,
    output logic            auto_adjust_o,
    output hpc_drive_s      drive_o,
    output logic            zero_cross_o,
    output logic            regs_hold_o
);
    if (HALF_PERIOD < 2) begin : g_bad_half_period
        $error("HALF_PERIOD too small");
    end

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    logic [3:0] meta_r;
    logic [3:0] sync_r;
    logic [2:0] gpi_d_r;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_r <= 4'h0;
            sync_r <= 4'h0;
        end else begin
            meta_r <= {pwm_stream_input_pin_i, gpi_i};
            sync_r <= meta_r;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            gpi_d_r <= 3'h0;
        end else begin
            gpi_d_r <= sync_r[2:0];
        end
    end

    // per-gpi edge config: 0 rising, 1 falling, 2 both
    logic [2:0] gpi_evt;
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_gpi
            logic [1:0] cfg;
            logic       rise;
            logic       fall;
            assign cfg  = gpi_edge_cfg_i[2*g +: 2];
            assign rise = sync_r[g] & ~gpi_d_r[g];
            assign fall = ~sync_r[g] & gpi_d_r[g];
            assign gpi_evt[g] = (cfg == 2'h0) ? rise :
                                (cfg == 2'h1) ? fall :
                                (cfg == 2'h2) ? (rise | fall) : 1'b0;
        end
    endgenerate

    // ------------------------------------------------------------------
    // system state machine
    // ------------------------------------------------------------------
    localparam int BOOT_W = $clog2(BOOT_CYCLES + 1);
    hpc_state_e  state_r;
    hpc_state_e  state_nxt;
    logic [BOOT_W-1:0] boot_cnt_r;
    logic        start_req;
    logic        stream_src;

    assign stream_src = (source_sel_i == SRC_REG_STREAM) | (source_sel_i == SRC_PWM_STREAM);

    always_comb begin
        unique case (source_sel_i)
            SRC_REG_TRIG:   start_req = sequence_trigger_i;
            SRC_EDGE_TRIG:  start_req = sequence_trigger_i | (|gpi_evt);
            SRC_REG_STREAM: start_req = 1'b1;
            SRC_PWM_STREAM: start_req = 1'b1;
            default:        start_req = 1'b0;
        endcase
    end

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_BOOT: begin
                if (boot_cnt_r == BOOT_W'(BOOT_CYCLES)) state_nxt = ST_IDLE;
            end
            ST_IDLE, ST_STANDBY: begin
                if (start_req && !fault_i) state_nxt = ST_DRIVE;
            end
            ST_DRIVE: begin
                if ((!stream_src && sequence_done_i) ||
                    (stream_src && !start_req) ||
                    (source_sel_i == SRC_INACTIVE)) begin
                    state_nxt = standby_en_i ? ST_STANDBY : ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
        if (fault_i && state_r != ST_BOOT) state_nxt = ST_IDLE;
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= ST_BOOT;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            boot_cnt_r <= '0;
        end else if (state_r == ST_BOOT) begin
            boot_cnt_r <= boot_cnt_r + BOOT_W'(1);
        end
    end

    assign state_o     = state_r;
    assign regs_hold_o = (state_r == ST_IDLE) | (state_r == ST_STANDBY);

    // ------------------------------------------------------------------
    // loop mode
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            back_emf_enable_o <= 1'b0;
            auto_adjust_o     <= 1'b0;
        end else begin
            back_emf_enable_o <= closed_loop_i & (state_r == ST_DRIVE);
            auto_adjust_o     <= closed_loop_i & (state_r == ST_DRIVE);
        end
    end

    // ------------------------------------------------------------------
    // zero-cross timer, free running on the core clock
    // ------------------------------------------------------------------
    // not derived from the input pwm, so output rate never follows it
    localparam int HP_W = $clog2(HALF_PERIOD + 1);
    logic [HP_W-1:0] hp_cnt_r;
    logic            zc;

    assign zc = (hp_cnt_r == HP_W'(HALF_PERIOD - 1));

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            hp_cnt_r <= '0;
        end else if (zc) begin
            hp_cnt_r <= '0;
        end else begin
            hp_cnt_r <= hp_cnt_r + HP_W'(1);
        end
    end
    assign zero_cross_o = zc;

    // ------------------------------------------------------------------
    // pwm demodulation
    // ------------------------------------------------------------------
    logic [7:0] duty;
    logic       duty_valid;
    logic [7:0] pwm_level_r;

    hpc_pwm_demod #(
        .CNT_W (PWM_CNT_W)
    ) u_demod (
        .core_clk_i   (core_clk_i),
        .rst_i        (rst_i),
        .pwm_sync_i   (sync_r[3]),
        .duty_o       (duty),
        .duty_valid_o (duty_valid)
    );

    // pwm duty to level in the same encoding as the streamed register
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pwm_level_r <= LVL_ZERO;
        end else if (duty_valid) begin
            if (duty < min_duty_threshold_i) begin
                pwm_level_r <= LVL_ZERO;
            end else if (boost_en_i) begin
                pwm_level_r <= {1'b0, duty[7:1]};
            end else begin
                pwm_level_r <= duty ^ 8'h80;
            end
        end
    end

    // ------------------------------------------------------------------
    // drive level, sampled at zero crossings
    // ------------------------------------------------------------------
    logic [7:0] req_level;
    logic [7:0] mag;
    logic       neg;
    logic       req_zero;

    assign req_level = (source_sel_i == SRC_PWM_STREAM) ? pwm_level_r
                                                         : streamed_drive_level_i;

    always_comb begin
        neg = 1'b0;
        mag = req_level;
        if (boost_en_i) begin
            // codes 80..ff unused with boost on, treated as zero
            mag = req_level[7] ? LVL_ZERO : req_level;
        end else if (req_level[7]) begin
            neg = 1'b1;
            mag = (req_level == LVL_NEG_FULL) ? LVL_POS_FULL : 8'(-req_level);
        end
    end
    assign req_zero = (mag == LVL_ZERO);

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            drive_o <= '0;
        end else if (state_r != ST_DRIVE || !stream_src) begin
            drive_o <= '0;
        end else if (zc) begin
            drive_o.enable    <= !req_zero;
            drive_o.magnitude <= mag;
            drive_o.negative  <= neg;
            drive_o.use_peak  <= !boost_en_i;
        end
    end

    // is_lra_i only selects how the downstream bridge realises a negative level
    logic unused_lra;
    assign unused_lra = is_lra_i;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_fault_idle;
        @(posedge core_clk_i) disable iff (rst_i)
        (fault_i && state_r != ST_BOOT) |=> (state_r == ST_IDLE);
    endproperty
    a_fault_idle: assert property (p_fault_idle) else $error("fault not to idle");

    property p_boot_len;
        @(posedge core_clk_i) disable iff (rst_i)
        $rose(state_r == ST_IDLE) && $past(state_r) == ST_BOOT |->
            $past(boot_cnt_r) == BOOT_W'(BOOT_CYCLES);
    endproperty
    a_boot_len: assert property (p_boot_len) else $error("boot length wrong");

    property p_open_loop;
        @(posedge core_clk_i) disable iff (rst_i)
        !closed_loop_i |=> !back_emf_enable_o && !auto_adjust_o;
    endproperty
    a_open_loop: assert property (p_open_loop) else $error("open loop still adjusts");

    property p_done_target;
        @(posedge core_clk_i) disable iff (rst_i)
        (state_r == ST_DRIVE && !fault_i && !stream_src && sequence_done_i) |=>
            (state_r == ($past(standby_en_i) ? ST_STANDBY : ST_IDLE));
    endproperty
    a_done_target: assert property (p_done_target) else $error("bad end state");

    property p_trig_only;
        @(posedge core_clk_i) disable iff (rst_i)
        ((state_r == ST_IDLE || state_r == ST_STANDBY) &&
         source_sel_i == SRC_REG_TRIG && !sequence_trigger_i)
            |=> state_r != ST_DRIVE;
    endproperty
    a_trig_only: assert property (p_trig_only) else $error("start without trigger");

    property p_inactive_wait;
        @(posedge core_clk_i) disable iff (rst_i)
        ((state_r == ST_IDLE || state_r == ST_STANDBY) && source_sel_i == SRC_INACTIVE)
            |=> state_r != ST_DRIVE;
    endproperty
    a_inactive_wait: assert property (p_inactive_wait) else $error("inactive started");

    property p_zc_only;
        @(posedge core_clk_i) disable iff (rst_i)
        (state_r == ST_DRIVE && $past(state_r) == ST_DRIVE && stream_src && !zc)
            |=> $stable(drive_o.magnitude);
    endproperty
    a_zc_only: assert property (p_zc_only) else $error("level moved off zero cross");

    property p_zero_off;
        @(posedge core_clk_i) disable iff (rst_i)
        (state_r == ST_DRIVE && stream_src && zc && req_zero) |=> !drive_o.enable;
    endproperty
    a_zero_off: assert property (p_zero_off) else $error("zero level still drives");

    // gap counter kept apart from the timer it checks; catches early and missing pulses
    logic [HP_W-1:0] zc_gap_r;
    logic            zc_seen_r;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            zc_gap_r  <= '0;
            zc_seen_r <= 1'b0;
        end else begin
            zc_gap_r  <= zc ? '0 : zc_gap_r + HP_W'(1);
            zc_seen_r <= zc_seen_r | zc;
        end
    end

    property p_zc_period;
        @(posedge core_clk_i) disable iff (rst_i)
        zc_seen_r |-> (zc == (zc_gap_r == HP_W'(HALF_PERIOD - 1)));
    endproperty
    a_zc_period: assert property (p_zc_period) else $error("zero cross timer off");

    c_drive: cover property (@(posedge core_clk_i) disable iff (rst_i)
        state_r == ST_IDLE ##1 state_r == ST_DRIVE);
    c_standby: cover property (@(posedge core_clk_i) disable iff (rst_i)
        state_r == ST_DRIVE ##1 state_r == ST_STANDBY);
    c_neg: cover property (@(posedge core_clk_i) disable iff (rst_i)
        drive_o.enable && drive_o.negative);
endmodule : hpc_top
`default_nettype wire

// *** core/hpc_pkg.sv ***
// package for the haptic playback mode control block
// assumes a single 100 MHz core clock; no register bus, all controls are ports
package hpc_pkg;

    // ------------------------------------------------------------------
    // playback source select codes
    // ------------------------------------------------------------------
    localparam logic [2:0] SRC_INACTIVE   = 3'h0;
    localparam logic [2:0] SRC_REG_STREAM = 3'h1;
    localparam logic [2:0] SRC_PWM_STREAM = 3'h2;
    localparam logic [2:0] SRC_REG_TRIG   = 3'h3;
    localparam logic [2:0] SRC_EDGE_TRIG  = 3'h4;

    // ------------------------------------------------------------------
    // levels and timing
    // ------------------------------------------------------------------
    localparam logic [7:0] LVL_ZERO        = 8'h00;
    localparam logic [7:0] LVL_POS_FULL    = 8'h7f;
    localparam logic [7:0] LVL_NEG_FULL    = 8'h80;
    localparam int         CLK_PERIOD_NS   = 10;
    localparam int         BOOT_TIME_NS    = 1000;
    localparam int         BOOT_CYCLES     = (BOOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int         HALF_PERIOD_DEF = 2000;
    localparam int         PWM_CNT_W       = 16;

    // ------------------------------------------------------------------
    // system states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_BOOT    = 4'h1,
        ST_IDLE    = 4'h2,
        ST_STANDBY = 4'h4,
        ST_DRIVE   = 4'h8
    } hpc_state_e;

    typedef struct packed {
        logic       enable;
        logic       negative;
        logic [7:0] magnitude;
        logic       use_peak;
    } hpc_drive_s;

endpackage : hpc_pkg

// *** core/hpc_pwm_demod.sv ***
// pwm input demodulator: measures duty of the synchronised input per period
// assumes pwm_sync_i is already on core_clk_i
`timescale 1ns/100ps
`default_nettype none
module hpc_pwm_demod
    import hpc_pkg::*;
#(
    parameter int CNT_W = PWM_CNT_W
) (
    input  wire logic             core_clk_i,
    input  wire logic             rst_i,
    input  wire logic             pwm_sync_i,
    output logic [7:0]            duty_o,
    output logic                  duty_valid_o
);
    if (CNT_W < 8) begin : g_bad_cnt_w
        $error("CNT_W too small");
    end

    logic             pwm_d_r;
    logic [CNT_W-1:0] period_cnt_r;
    logic [CNT_W-1:0] high_cnt_r;
    logic [CNT_W+7:0] scaled;
    logic             rise;

    assign rise   = pwm_sync_i & ~pwm_d_r;
    assign scaled = {high_cnt_r, 8'h00} - {8'h00, high_cnt_r};

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pwm_d_r      <= 1'b0;
            period_cnt_r <= '0;
            high_cnt_r   <= '0;
            duty_o       <= 8'h00;
            duty_valid_o <= 1'b0;
        end else begin
            pwm_d_r      <= pwm_sync_i;
            duty_valid_o <= 1'b0;
            if (rise) begin
                // duty in 0..255 as high/period
                if (period_cnt_r != '0) begin
                    duty_o <= 8'((scaled) / {8'h00, period_cnt_r});
                end
                duty_valid_o <= 1'b1;
                period_cnt_r <= CNT_W'(1);
                high_cnt_r   <= CNT_W'(1);
            end else if (period_cnt_r != '1) begin
                period_cnt_r <= period_cnt_r + CNT_W'(1);
                if (pwm_sync_i) begin
                    high_cnt_r <= high_cnt_r + CNT_W'(1);
                end
            end
        end
    end
endmodule : hpc_pwm_demod
`default_nettype wire

// *** tb/hpc_pwm_src.sv ***
// pwm source model standing on the far side of the pwm stream input pin
// assumes high and period counts in core clock cycles, held while running
`timescale 1ns/100ps
`default_nettype none
module hpc_pwm_src (
    input  wire logic        clk_i,
    input  wire logic [15:0] high_i,
    input  wire logic [15:0] period_i,
    output logic             pin_o
);
    logic [15:0] cnt_r = 16'h0000;

    // free running so the signal is already present before pwm streaming is chosen
    always_ff @(posedge clk_i) begin
        cnt_r <= (cnt_r + 16'h0001 >= period_i) ? 16'h0000 : cnt_r + 16'h0001;
        pin_o <= (cnt_r < high_i);
    end
endmodule : hpc_pwm_src
`default_nettype wire

// *** tb/hpc_top_tb.sv ***
// self-checking bench for the haptic playback mode control block
// assumes hpc_pkg and hpc_top compiled first; short half period for speed
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module hpc_top_tb
    import hpc_pkg::*;
;
    localparam int HP = 8;
    logic clk = 1'b0, rst = 1'b1, sby = 1'b0, boost = 1'b0, cl = 1'b0, lra = 1'b0;
    logic wr = 1'b0, trig = 1'b0, done = 1'b0, fault = 1'b0, pwm;
    logic [2:0]  src = 3'h0, gpi = 3'h0;
    logic [5:0]  ecfg = 6'h3f;
    logic [7:0]  lvl = 8'h00, thr = 8'h00;
    logic [15:0] ph = 16'h0000, pp = 16'd51;
    logic [31:0] seed = 32'hd760105a;
    int failures = 0, n_compared = 0, cycles = 0, k;
    hpc_state_e state;
    hpc_drive_s drv;
    logic emf_en, adj, zc, hold;
    logic [7:0] lvls[$] = '{8'h00, 8'h01, 8'h7f, 8'h80, 8'h81, 8'hff};

    hpc_top #(.HALF_PERIOD(HP)) i_dut (.core_clk_i(clk), .rst_i(rst), .source_sel_i(src),
        .standby_en_i(sby), .boost_en_i(boost), .closed_loop_i(cl), .is_lra_i(lra),
        .streamed_drive_level_i(lvl), .streamed_level_wr_i(wr), .min_duty_threshold_i(thr),
        .sequence_trigger_i(trig), .sequence_done_i(done), .fault_i(fault), .gpi_i(gpi),
        .gpi_edge_cfg_i(ecfg), .pwm_stream_input_pin_i(pwm), .state_o(state),
        .back_emf_enable_o(emf_en), .auto_adjust_o(adj), .drive_o(drv), .zero_cross_o(zc),
        .regs_hold_o(hold));
    hpc_pwm_src i_src (.clk_i(clk), .high_i(ph), .period_i(pp), .pin_o(pwm));

    initial begin
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // reference model and helpers
    // ------------------------------------------------------------------
    function automatic hpc_drive_s exp_drv(input int l, input bit bst);
        hpc_drive_s d;
        int m;
        d = '0;
        if (bst) m = (l < 128) ? l : 0;
        else m = (l < 128) ? l : ((l == 128) ? 127 : 256 - l);
        d.negative = !bst && (l >= 128);
        d.magnitude = m[7:0];
        d.enable = (m != 0);
        d.use_peak = !bst;
        return d;
    endfunction : exp_drv

    // duty on a 0..255 scale, measured in whole clock cycles
    function automatic int pwm_lvl(input int h, input int p, input int t, input bit bst);
        int duty;
        duty = h * 255 / p;
        if (duty < t) return 0;
        return bst ? duty / 2 : (duty ^ 128);
    endfunction : pwm_lvl

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    localparam bit P_TRIG = 1'b0;
    localparam bit P_DONE = 1'b1;

    task automatic pulse(input bit is_done);
        @(posedge clk);
        if (is_done) done <= 1'b1;
        else trig <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        trig <= 1'b0;
    endtask : pulse

    task automatic wait_st(input hpc_state_e s, input int lim, input string nm);
        int i;
        @(negedge clk);
        for (i = 0; i < lim && state !== s; i++) @(negedge clk);
        `CHK(nm, s, state)
    endtask : wait_st

    // one gpi edge: it either starts a sequence that then ends, or is ignored
    task automatic edge_step(input bit go, input string nm);
        if (go) begin
            wait_st(ST_DRIVE, 8, nm);
            pulse(P_DONE);
            wait_st(ST_IDLE, 3, "done to idle");
        end else begin
            tick(8);
            wait_st(ST_IDLE, 0, nm);
        end
    endtask : edge_step

    // two zero crosses are awaited so a change near a crossing cannot race it
    task automatic chk_drv(input hpc_drive_s e, input string nm);
        int i;
        repeat (2) begin
            @(negedge clk);
            for (i = 0; i < 3 * HP && zc !== 1'b1; i++) @(negedge clk);
        end
        repeat (2) @(negedge clk);
        `CHK(nm, e, drv)
    endtask : chk_drv

    task automatic set_lvl(input logic [7:0] v, input logic b);
        @(posedge clk);
        lvl <= v;
        boost <= b;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : set_lvl

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : close_out

    always @(posedge clk) begin
        cycles++;
        if (cycles == 10000) begin
            failures++;
            close_out();
        end
    end

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    initial begin
        tick(15);
        @(negedge clk);
        `CHK("reset state", ST_BOOT, state)
        `CHK("reset drive", hpc_drive_s'('0), drv)
        @(posedge clk);
        rst <= 1'b0;
        tick(BOOT_CYCLES - 10);
        @(negedge clk);
        `CHK("boot running", ST_BOOT, state)
        wait_st(ST_IDLE, 30, "boot to idle");
        `CHK("idle hold", 1'b1, hold)
        pulse(P_TRIG);
        tick(10);
        wait_st(ST_IDLE, 0, "inactive stays");
        $display("test boot_inactive done");

        set_lvl(8'h40, 1'b1);
        @(posedge clk);
        src <= SRC_REG_STREAM;
        wait_st(ST_DRIVE, 3, "stream start");
        `CHK("drive hold", 1'b0, hold)
        for (k = 0; k < 2 * lvls.size(); k++) begin
            set_lvl(lvls[k % lvls.size()], k < lvls.size());
            cl <= k[0];
            chk_drv(exp_drv(lvls[k % lvls.size()], k < lvls.size()), "stream level");
            `CHK("back emf", cl, emf_en)
            `CHK("auto adjust", cl, adj)
        end
        for (k = 0; k < 6; k++) begin
            seed = xs(seed);
            set_lvl(seed[7:0], seed[8]);
            lra <= seed[9];
            chk_drv(exp_drv(seed[7:0], seed[8]), "random level");
        end
        set_lvl(8'h00, 1'b1);
        chk_drv(exp_drv(0, 1), "zero level");
        @(posedge clk);
        lvl <= 8'h7f;
        @(negedge clk);
        `CHK("held between crossings", exp_drv(0, 1), drv)
        chk_drv(exp_drv(127, 1), "re-enable");
        $display("test reg_stream done");

        @(posedge clk);
        fault <= 1'b1;
        wait_st(ST_IDLE, 2, "fault to idle");
        tick(5);
        wait_st(ST_IDLE, 0, "fault blocks start");
        @(posedge clk);
        fault <= 1'b0;
        wait_st(ST_DRIVE, 5, "start after fault");
        @(posedge clk);
        sby <= 1'b1;
        src <= SRC_INACTIVE;
        wait_st(ST_STANDBY, 3, "stream end standby");
        `CHK("standby hold", 1'b1, hold)
        $display("test fault_end done");

        @(posedge clk);
        src <= SRC_REG_TRIG;
        ecfg <= 6'h00;
        gpi <= 3'b001;
        tick(8);
        wait_st(ST_STANDBY, 0, "gpi ignored");
        @(posedge clk);
        gpi <= 3'b000;
        pulse(P_TRIG);
        wait_st(ST_DRIVE, 3, "trigger start");
        pulse(P_DONE);
        wait_st(ST_STANDBY, 3, "done to standby");
        @(posedge clk);
        sby <= 1'b0;
        src <= SRC_EDGE_TRIG;
        // gpi k gets edge config k (rising, falling, both), the others are disabled
        for (k = 0; k < 3; k++) begin
            @(posedge clk);
            ecfg <= 6'h3f & ~(6'(3 - k) << (2 * k));
            gpi[k] <= 1'b1;
            edge_step(k != 1, "gpi rise");
            @(posedge clk);
            gpi[k] <= 1'b0;
            edge_step(k != 0, "gpi fall");
        end
        pulse(P_TRIG);
        wait_st(ST_DRIVE, 3, "edge mode trigger");
        pulse(P_DONE);
        wait_st(ST_IDLE, 3, "edge mode done");
        $display("test triggered done");

        @(posedge clk);
        ph <= 16'd20;
        tick(120);
        src <= SRC_PWM_STREAM;
        wait_st(ST_DRIVE, 3, "pwm start");
        for (k = 0; k < 5; k++) begin
            @(posedge clk);
            ph <= 16'(k == 0 ? 20 : k == 1 ? 40 : k == 4 ? 30 : 10);
            boost <= (k != 1 && k != 2);
            thr <= (k == 2) ? 8'd40 : 8'd60;
            tick(160);
            chk_drv(exp_drv(pwm_lvl(int'(ph), 51, int'(thr), boost), boost), "pwm");
        end
        @(negedge clk);
        for (k = 1; k < 3 * HP && zc !== 1'b1; k++) @(negedge clk);
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (zc !== 1'b1 && k < 3 * HP);
        `CHK("zero cross spacing", HP, k)
        $display("test pwm_stream done");
        close_out();
    end
endmodule : hpc_top_tb
`default_nettype wire
